// ==== dv/afpp_host_sva.sv ====
/* Checker on the host controller pins and request handshake.
   Bound to afpp_host; sees only its ports. */
`timescale 1ns/1ps
module afpp_host_sva
    import afpp_pkg::*;
(
    // Watched ports
    input wire logic              core_clk_i,
    input wire logic              rstn_i,
    input wire logic              req_valid_i,
    input wire logic              req_ready_o,
    input wire logic              rsp_valid_o,
    input wire logic              sleep_req_i,
    input wire afpp_pins_t        pins_o,
    input wire logic [DATA_W-1:0] data_io_o,
    input wire logic [1:0]        data_io_oe_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rstn_i);
    // ----------------------------------------
    // Pin protocol and request handshake
    // ----------------------------------------
    property p_prechg;
        $fell(pins_o.chip_sel_n) |-> $past(pins_o.chip_sel_n, 11)
            && $past(pins_o.chip_sel_n, 6);
    endproperty
    a_prechg: assert property (p_prechg) else $error("short precharge");
    property p_sleep;
        !pins_o.chip_sel_n |-> pins_o.sleep_n;
    endproperty
    a_sleep: assert property (p_sleep) else $error("select in sleep");
    property p_acc;
        $rose(pins_o.write_n) |-> !$past(pins_o.write_n, 11);
    endproperty
    a_acc: assert property (p_acc) else $error("write strobe short");
    property p_setup;
        $rose(pins_o.write_n) |-> $past(data_io_o, 3) == data_io_o
            && $past(data_io_o) == data_io_o;
    endproperty
    a_setup: assert property (p_setup) else $error("data not set up");
    property p_drive;
        |data_io_oe_o |-> !pins_o.write_n || !$past(pins_o.write_n);
    endproperty
    a_drive: assert property (p_drive) else $error("bus driven on read");
    property p_endwr;
        $rose(pins_o.chip_sel_n) |-> pins_o.write_n && $past(pins_o.write_n);
    endproperty
    a_endwr: assert property (p_endwr) else $error("select ends write");
    property p_strobe;
        $fell(pins_o.write_n) |-> ##[11:20] $rose(pins_o.write_n);
    endproperty
    a_strobe: assert property (p_strobe) else $error("strobe stuck");
    property p_row;
        !pins_o.chip_sel_n && $changed(pins_o.word_address)
            |-> $past(pins_o.write_n);
    endproperty
    a_row: assert property (p_row) else $error("address moved in write");
    property p_ans;
        req_valid_i && req_ready_o && !sleep_req_i
            |=> !req_ready_o ##[3:60] rsp_valid_o;
    endproperty
    a_ans: assert property (p_ans) else $error("no answer");
    c_wr: cover property ($fell(pins_o.write_n));
    c_sl: cover property (!pins_o.sleep_n);
    c_rd: cover property (rsp_valid_o && pins_o.write_n);
endmodule
bind afpp_host afpp_host_sva u_sva (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
    .req_valid_i(req_valid_i), .req_ready_o(req_ready_o),
    .rsp_valid_o(rsp_valid_o), .sleep_req_i(sleep_req_i), .pins_o(pins_o),
    .data_io_o(data_io_o), .data_io_oe_o(data_io_oe_o));

// ==== dv/afpp_mem_model.sv ====
/* Behavioural model of the clockless parallel memory.
   Assumes the bench merges its lane drive with the host onto one bus. */
`timescale 1ns/1ps
module afpp_mem_model
    import afpp_pkg::*;
#(
    // One ns early so data never lands on a sampling edge
    parameter int ACC_NS = ACCESS_NS - 1
)
(
    // Pins and bus
    input  wire afpp_pins_t        pins_i,
    input  wire logic [DATA_W-1:0] wdata_i,
    output logic [DATA_W-1:0]      rdata_o,
    output logic [1:0]             drive_o
);
    logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
    logic [ADDR_W-3:0] row;
    logic [1:0]        col;
    logic              valid = 1'b0;
    logic              wr_open = 1'b0;
    event              open_ev;
    // Column-only changes must not restart the access
    always @(negedge pins_i.chip_sel_n)
        if (pins_i.sleep_n) ->open_ev;
    always @(pins_i.word_address)
        if (!pins_i.chip_sel_n && pins_i.sleep_n
            && pins_i.word_address[ADDR_W-1:2] != row) ->open_ev;
    always @(open_ev) begin
        row = pins_i.word_address[ADDR_W-1:2];
        valid = 1'b0;
        #(ACC_NS) valid = 1'b1;
    end
    always @(posedge pins_i.chip_sel_n) valid = 1'b0;
    always @(negedge pins_i.write_n)
        if (!pins_i.chip_sel_n && pins_i.sleep_n) begin
            wr_open = 1'b1;
            col = pins_i.word_address[1:0];
        end
    always @(posedge pins_i.write_n or posedge pins_i.chip_sel_n)
        if (wr_open) begin
            wr_open = 1'b0;
            if (!pins_i.upper_byte_sel_n)
                mem[{row, col}][15:8] = wdata_i[15:8];
            if (!pins_i.lower_byte_sel_n)
                mem[{row, col}][7:0] = wdata_i[7:0];
        end
    assign rdata_o = mem[{row, pins_i.word_address[1:0]}];
    assign drive_o = {2{valid && pins_i.write_n && !pins_i.out_en_n
        && !pins_i.chip_sel_n && pins_i.sleep_n}}
        & ~{pins_i.upper_byte_sel_n, pins_i.lower_byte_sel_n};
endmodule

// ==== dv/tb_async_fram_parallel_port.sv ====
/* Self-checking bench: host controller against the memory model.
   Released lanes show the inverse of the memory word. */
`timescale 1ns/1ps
module tb_async_fram_parallel_port;
    import afpp_pkg::*;
    logic              core_clk_i, rstn_i, req_valid_i, sleep_req_i;
    logic              req_ready_o, rsp_valid_o, asleep_o;
    afpp_req_t         req_i;
    afpp_pins_t        pins_o;
    logic [DATA_W-1:0] rsp_rdata_o, data_io_i, data_io_o, mem_rd, rd;
    logic [1:0]        data_io_oe_o, mem_drv;
    int                n_fail = 0;
    int                checks_done = 0;
    afpp_host uut (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
        .req_valid_i(req_valid_i), .req_i(req_i), .req_ready_o(req_ready_o),
        .rsp_valid_o(rsp_valid_o), .rsp_rdata_o(rsp_rdata_o),
        .sleep_req_i(sleep_req_i), .asleep_o(asleep_o), .pins_o(pins_o),
        .data_io_i(data_io_i), .data_io_o(data_io_o),
        .data_io_oe_o(data_io_oe_o));
    afpp_mem_model mem (.pins_i(pins_o), .wdata_i(data_io_i),
        .rdata_o(mem_rd), .drive_o(mem_drv));
    always_comb begin
        for (int l = 0; l < 2; l++)
            data_io_i[l*8 +: 8] = data_io_oe_o[l] ? data_io_o[l*8 +: 8] :
                mem_drv[l] ? mem_rd[l*8 +: 8] : ~mem_rd[l*8 +: 8];
    end
    initial begin
        core_clk_i = 1'b0;
        forever #2.5 core_clk_i = ~core_clk_i;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic xfer(input logic w, input logic [17:0] a,
                        input logic [15:0] d, input logic [1:0] en);
        for (int i = 0; i < 200 && req_ready_o !== 1'b1; i++)
            @(negedge core_clk_i);
        req_i = '{w, a, d, en[1], en[0]};
        req_valid_i = 1'b1;
        @(negedge core_clk_i);
        req_valid_i = 1'b0;
        chk(req_ready_o, 1'b0);
        for (int i = 0; i < 200 && rsp_valid_o !== 1'b1; i++)
            @(negedge core_clk_i);
        chk(rsp_valid_o, 1'b1);
        rd = rsp_rdata_o;
        @(negedge core_clk_i);
        chk({rsp_valid_o, req_ready_o}, 2'h1);
    endtask
    task automatic t_reset;
        chk(pins_o, PINS_IDLE);
        chk(data_io_oe_o, 2'h0);
        $display("t_reset done");
    endtask
    task automatic t_bytes;
        xfer(1'b1, 18'h2AAA5, 16'hA55A, 2'h3);
        xfer(1'b0, 18'h2AAA5, 16'h0000, 2'h3);
        chk(rd, 16'hA55A);
        xfer(1'b1, 18'h2AAA5, 16'h00C3, 2'h1);
        xfer(1'b0, 18'h2AAA5, 16'h0000, 2'h3);
        chk(rd, 16'hA5C3);
        xfer(1'b0, 18'h2AAA5, 16'h0000, 2'h2);
        chk(rd[15:8], 8'hA5);
        chk(rd[7:0], 8'h3C);
        $display("t_bytes done");
    endtask
    task automatic t_page;
        for (int c = 0; c < 4; c++)
            xfer(1'b1, {16'hFFFF, 2'(c)}, 16'hC0D0 + 16'(c), 2'h3);
        for (int c = 3; c >= 0; c--) begin
            xfer(1'b0, {16'hFFFF, 2'(c)}, 16'h0000, 2'h3);
            chk(rd, 16'hC0D0 + 16'(c));
        end
        $display("t_page done");
    endtask
    task automatic t_rows;
        xfer(1'b1, 18'h00000, 16'h1357, 2'h3);
        xfer(1'b1, 18'h20004, 16'h2468, 2'h3);
        xfer(1'b0, 18'h00000, 16'h0000, 2'h3);
        chk(rd, 16'h1357);
        xfer(1'b0, 18'h20004, 16'h0000, 2'h3);
        chk(rd, 16'h2468);
        $display("t_rows done");
    endtask
    task automatic t_sleep;
        sleep_req_i = 1'b1;
        for (int i = 0; i < 200 && asleep_o !== 1'b1; i++)
            @(negedge core_clk_i);
        chk({asleep_o, pins_o.sleep_n}, 2'h2);
        req_i = '{1'b1, 18'h00000, 16'hDEAD, 1'b1, 1'b1};
        req_valid_i = 1'b1;
        repeat (8) begin
            @(negedge core_clk_i);
            chk({pins_o.chip_sel_n, rsp_valid_o}, 2'h2);
        end
        req_valid_i = 1'b0;
        sleep_req_i = 1'b0;
        for (int i = 0; i < 200 && asleep_o !== 1'b0; i++)
            @(negedge core_clk_i);
        chk({asleep_o, pins_o.sleep_n}, 2'h1);
        xfer(1'b0, 18'h00000, 16'h0000, 2'h3);
        chk(rd, 16'h1357);
        $display("t_sleep done");
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge core_clk_i);
        n_fail++;
        test_done();
    end
    initial begin
        rstn_i = 1'b0;
        req_valid_i = 1'b0;
        sleep_req_i = 1'b0;
        req_i = '0;
        repeat (3) @(posedge core_clk_i);
        @(negedge core_clk_i);
        rstn_i = 1'b1;
        t_reset();
        t_bytes();
        t_page();
        t_rows();
        t_sleep();
        test_done();
    end
endmodule

// ==== hdl/afpp_host.sv ====
/*
 * Host controller driving the memory pins. One request at a time; keeps
 * the row open between requests to the same row for page-mode access.
 * Assumes requests synchronous to core_clk_i and a memory meeting its
 * access time held in the package constants.
 */
`timescale 1ns/1ps
module afpp_host
    import afpp_pkg::*;
(
    // Clock and reset
    input  wire logic              core_clk_i,
    input  wire logic              rstn_i,
    // Request side
    input  wire logic              req_valid_i,
    input  wire afpp_req_t         req_i,
    output logic                   req_ready_o,
    output logic                   rsp_valid_o,
    output logic [DATA_W-1:0]      rsp_rdata_o,
    // Sleep request, level
    input  wire logic              sleep_req_i,
    output logic                   asleep_o,
    // Memory pins
    output afpp_pins_t             pins_o,
    input  wire logic [DATA_W-1:0] data_io_i,
    output logic [DATA_W-1:0]      data_io_o,
    output logic [1:0]             data_io_oe_o
);

    typedef enum {
        ST_IDLE, ST_PRECHARGE, ST_ACCESS, ST_WSETUP, ST_GAP, ST_SLEEP
    } afpp_state_t;

    afpp_state_t       state, next_state;
    afpp_pins_t        pins, next_pins;
    logic [DATA_W-1:0] wdata, next_wdata;
    logic [1:0]        oe, next_oe;
    logic [CNT_W-1:0]  cnt, next_cnt;
    logic [CNT_W-1:0]  rc_cnt, next_rc_cnt;
    logic              row_open, next_row_open;
    logic              ready, next_ready;
    logic              rsp_valid, next_rsp_valid;
    logic [DATA_W-1:0] rdata, next_rdata;
    logic              asleep, next_asleep;
    logic              is_write, next_is_write;
    logic              same_row;

    assign same_row = row_open &&
        (req_i.word_address[ADDR_W-1:COL_W] ==
         pins.word_address[ADDR_W-1:COL_W]);

    // ------------------------------------------------------------------
    // Access sequencer
    // ------------------------------------------------------------------
    always_comb begin
        next_state     = state;
        next_pins      = pins;
        next_wdata     = wdata;
        next_oe        = oe;
        next_cnt       = (cnt != CNT_ZERO) ? cnt - 6'h01 : cnt;
        next_rc_cnt    = (rc_cnt != CNT_ZERO) ? rc_cnt - 6'h01 : rc_cnt;
        next_row_open  = row_open;
        next_ready     = 1'b0;
        next_rsp_valid = 1'b0;
        next_rdata     = rdata;
        next_asleep    = asleep;
        next_is_write  = is_write;
        case (state)
            ST_IDLE: begin
                if (sleep_req_i) begin
                    // Close the row as sleep_n falls, same cycle; sleep only between accesses
                    next_pins     = PINS_IDLE;
                    next_pins.sleep_n = 1'b0;
                    next_row_open = 1'b0;
                    next_cnt      = CNT_W'(PRECHARGE_CYC);
                    next_state    = ST_SLEEP;
                end else if (req_valid_i && ready) begin
                    next_is_write = req_i.write;
                    // Held past strobe rise until the next request
                    next_wdata    = req_i.wdata;
                    next_pins.word_address = req_i.word_address;
                    next_pins.upper_byte_sel_n = ~req_i.upper_en;
                    next_pins.lower_byte_sel_n = ~req_i.lower_en;
                    if (same_row) begin
                        // Column change only: page access
                        next_cnt   = CNT_W'(PAGE_CYCLE_CYC);
                        next_state = ST_ACCESS;
                    end else if (row_open) begin
                        // New row: pre-charge via select high
                        next_pins.chip_sel_n = 1'b1;
                        next_pins.out_en_n   = 1'b1;
                        next_row_open        = 1'b0;
                        next_cnt   = CNT_W'(PRECHARGE_CYC);
                        next_state = ST_PRECHARGE;
                    end else begin
                        next_cnt   = CNT_W'(PRECHARGE_CYC);
                        next_state = ST_PRECHARGE;
                    end
                    if (req_i.write) begin
                        next_pins.out_en_n = 1'b1;
                    end
                end else begin
                    next_ready = 1'b1;
                end
            end
            ST_PRECHARGE: begin
                // Pre-charge and random cycle spacing both gate reopening
                if (cnt == CNT_ZERO && rc_cnt == CNT_ZERO) begin
                    // Select falls: address latched, access opens
                    next_pins.chip_sel_n = 1'b0;
                    next_row_open        = 1'b1;
                    next_rc_cnt = CNT_W'(RANDOM_CYCLE_CYC);
                    next_cnt    = CNT_W'(ACCESS_CYC);
                    if (is_write) begin
                        // Strobe falls with select: strobe-controlled write
                        next_pins.write_n = 1'b0;
                        next_oe = {~next_pins.upper_byte_sel_n,
                                   ~next_pins.lower_byte_sel_n};
                    end else begin
                        next_pins.out_en_n = 1'b0;
                    end
                    next_state = ST_ACCESS;
                end
            end
            ST_ACCESS: begin
                if (is_write && pins.write_n) begin
                    // Page write: fresh strobe fall for this column
                    next_pins.out_en_n = 1'b1;
                    next_pins.write_n  = 1'b0;
                    next_oe = {~pins.upper_byte_sel_n,
                               ~pins.lower_byte_sel_n};
                    next_cnt = CNT_W'(ACCESS_CYC);
                end else if (!is_write && pins.out_en_n) begin
                    next_pins.out_en_n = 1'b0;
                end else if (cnt == CNT_ZERO) begin
                    if (is_write) begin
                        next_cnt   = CNT_W'(DATA_SETUP_CYC);
                        next_state = ST_WSETUP;
                    end else begin
                        next_rdata     = data_io_i;
                        next_rsp_valid = 1'b1;
                        next_state     = ST_GAP;
                    end
                end
            end
            ST_WSETUP: begin
                if (cnt == CNT_ZERO) begin
                    // Strobe rises: write committed, no polling
                    next_pins.write_n = 1'b1;
                    next_rsp_valid    = 1'b1;
                    next_state        = ST_GAP;
                end
            end
            ST_GAP: begin
                // Release bus a cycle after strobe rise for hold margin
                next_oe    = 2'h0;
                next_ready = 1'b1;
                next_state = ST_IDLE;
            end
            ST_SLEEP: begin
                next_asleep = 1'b1;
                if (!sleep_req_i && cnt == CNT_ZERO) begin
                    next_pins.sleep_n = 1'b1;
                    next_asleep = 1'b0;
                    next_cnt    = CNT_W'(PRECHARGE_CYC);
                    next_ready  = 1'b1;
                    next_state  = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
                next_pins  = PINS_IDLE;
                next_oe    = 2'h0;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // State registers
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state     <= ST_IDLE;
            pins      <= PINS_IDLE;
            wdata     <= 16'h0000;
            oe        <= 2'h0;
            cnt       <= CNT_ZERO;
            rc_cnt    <= CNT_ZERO;
            row_open  <= 1'b0;
            ready     <= 1'b0;
            rsp_valid <= 1'b0;
            rdata     <= 16'h0000;
            asleep    <= 1'b0;
            is_write  <= 1'b0;
        end else begin
            state     <= next_state;
            pins      <= next_pins;
            wdata     <= next_wdata;
            oe        <= next_oe;
            cnt       <= next_cnt;
            rc_cnt    <= next_rc_cnt;
            row_open  <= next_row_open;
            ready     <= next_ready;
            rsp_valid <= next_rsp_valid;
            rdata     <= next_rdata;
            asleep    <= next_asleep;
            is_write  <= next_is_write;
        end
    end

    // ------------------------------------------------------------------
    // Outputs, all registered
    // ------------------------------------------------------------------
    assign req_ready_o  = ready;
    assign rsp_valid_o  = rsp_valid;
    assign rsp_rdata_o  = rdata;
    assign asleep_o     = asleep;
    assign pins_o       = pins;
    assign data_io_o    = wdata;
    assign data_io_oe_o = oe;

endmodule

// ==== hdl/afpp_pkg.sv ====
/*
 * Constants, types and pin timing for the host-side controller of an
 * asynchronous 256K x 16 nonvolatile parallel memory.
 * Assumes a single 200 MHz core clock; the memory itself is clockless.
 */
package afpp_pkg;

    localparam int ADDR_W = 18;
    localparam int DATA_W = 16;
    localparam int COL_W  = 2;

    localparam int CLK_PERIOD_PS = 5000;
    // Pin timing in ns
    localparam int ACCESS_NS        = 55;
    localparam int RANDOM_CYCLE_NS  = 110;
    localparam int PAGE_CYCLE_NS    = 25;
    localparam int PRECHARGE_NS     = 55;
    localparam int DATA_SETUP_NS    = 15;
    // Least times round up
    localparam int ACCESS_CYC       =
        (ACCESS_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int RANDOM_CYCLE_CYC =
        (RANDOM_CYCLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int PAGE_CYCLE_CYC   =
        (PAGE_CYCLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int PRECHARGE_CYC    =
        (PRECHARGE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int DATA_SETUP_CYC   =
        (DATA_SETUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    localparam int CNT_W = 6;
    localparam logic [CNT_W-1:0] CNT_ZERO = 6'h00;

    typedef struct packed {
        logic              write;
        logic [ADDR_W-1:0] word_address;
        logic [DATA_W-1:0] wdata;
        logic              upper_en;
        logic              lower_en;
    } afpp_req_t;

    typedef struct packed {
        logic              chip_sel_n;
        logic              write_n;
        logic              out_en_n;
        logic              upper_byte_sel_n;
        logic              lower_byte_sel_n;
        logic              sleep_n;
        logic [ADDR_W-1:0] word_address;
    } afpp_pins_t;

    localparam afpp_pins_t PINS_IDLE = '{
        chip_sel_n: 1'b1, write_n: 1'b1, out_en_n: 1'b1,
        upper_byte_sel_n: 1'b1, lower_byte_sel_n: 1'b1,
        sleep_n: 1'b1, word_address: 18'h00000};

endpackage
